// *** rtl/cswg_card.sv ***
// Purpose: card end, picks one status word per command
// Assumes: command fields arrive already decoded by the terminal link
// Notes:   file content rules are applied on the byte write port
`timescale 1ns/10ps
`include "cswg_consts.svh"
module cswg_card #(
    parameter int FILE_BYTES = 64
) (
    input  wire logic       mclk_i,
    input  wire logic       rst_i,
    cswg_if.card            lnk,
    input  wire logic       card_tk_i,
    input  wire logic       wr_en_i,
    input  wire logic       wr_clear_i,
    input  wire logic       wr_alpha_i,
    input  wire logic       wr_area_del_i,
    input  wire logic [5:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic [5:0] rd_addr_i,
    output logic      [7:0] rd_data_o,
    output logic            pend_proact_o
);
    cswg_pkg::cswg_sw_t sw;
    logic               take, fifo_rdy, tk_ok;
    logic               may_rsp, may_proact, err_hit;
    logic [7:0]         rd_data_d;
    logic               defer_q, defer_d;
    logic [7:0]         dlen_q, dlen_d;
    logic [7:0]         file_q [FILE_BYTES];

    assign tk_ok          = card_tk_i && lnk.term_tk;
    assign lnk.cmd_ready  = fifo_rdy;
    assign take           = lnk.cmd_valid && fifo_rdy;
    assign pend_proact_o  = defer_q;
    // any error status ends the command without touching the deferred state
    assign err_hit        = (lnk.cmd.cla != `CSWG_CLASS_OK) || lnk.cmd.len_bad ||
                            lnk.cmd.rec_range || lnk.cmd.p12_bad || lnk.cmd.fault;

    // permitted set per command: may it report a response length (9F) or
    // toolkit work (91); every command may still end with an error status
    always_comb begin
        may_rsp    = 1'b0;
        may_proact = 1'b0;
        case (lnk.cmd.cmd)
            cswg_pkg::CSWG_CMD_SELECT: begin
                may_rsp    = 1'b1;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_STATUS: begin
                may_rsp    = 1'b1;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_UPD_BIN: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_UPD_REC: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_RD_BIN: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_RD_REC: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_SEEK1: begin
                may_rsp    = 1'b1;
                may_proact = 1'b1;
            end
            // a type 2 seek never answers 91 itself; the news is held back
            cswg_pkg::CSWG_CMD_SEEK2: begin
                may_rsp    = 1'b1;
                may_proact = 1'b0;
            end
            cswg_pkg::CSWG_CMD_INCREASE: begin
                may_rsp    = 1'b1;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_CHV: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_INVAL: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_RUN_ALG: begin
                may_rsp    = 1'b1;
                may_proact = 1'b1;
            end
            // sleep never reports data or proactive work
            cswg_pkg::CSWG_CMD_SLEEP: begin
                may_rsp    = 1'b0;
                may_proact = 1'b0;
            end
            cswg_pkg::CSWG_CMD_GET_RSP: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_TERM_PROF: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_ENVELOPE: begin
                may_rsp    = 1'b1;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_FETCH: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            cswg_pkg::CSWG_CMD_TERM_RSP: begin
                may_rsp    = 1'b0;
                may_proact = 1'b1;
            end
            default: begin
                may_rsp    = 1'b0;
                may_proact = 1'b0;
            end
        endcase
    end

    // status priority: class, length, range, parameters, fault, then success;
    // a deferred 91 outranks fresh toolkit news on the get-response
    always_comb begin
        sw = '{sw1: `CSWG_SW1_OK, sw2: `CSWG_SW2_NONE};
        if (lnk.cmd.cla != `CSWG_CLASS_OK) begin
            sw = '{sw1: `CSWG_SW1_CLASS, sw2: `CSWG_SW2_NONE};
        end else if (lnk.cmd.len_bad) begin
            sw = '{sw1: `CSWG_SW1_LEN, sw2: lnk.cmd.exp_len};
        end else if (lnk.cmd.rec_range) begin
            sw = '{sw1: `CSWG_SW1_REF, sw2: `CSWG_SW2_RANGE};
        end else if (lnk.cmd.p12_bad) begin
            sw = '{sw1: `CSWG_SW1_P1P2, sw2: `CSWG_SW2_NONE};
        end else if (lnk.cmd.fault) begin
            sw = '{sw1: `CSWG_SW1_TECH, sw2: `CSWG_SW2_NONE};
        end else if (lnk.cmd.cmd == cswg_pkg::CSWG_CMD_GET_RSP && defer_q && tk_ok) begin
            sw = '{sw1: `CSWG_SW1_PROACT, sw2: dlen_q};
        end else if (may_proact && lnk.cmd.proact && tk_ok) begin
            sw = '{sw1: `CSWG_SW1_PROACT, sw2: lnk.cmd.proact_len};
        end else if (may_rsp && lnk.cmd.rsp_len != 8'h00) begin
            sw = '{sw1: `CSWG_SW1_RSPLEN, sw2: lnk.cmd.rsp_len};
        end
    end

    // deferred toolkit news: armed by a type 2 seek, spent by the get-response;
    // dropped when either end loses toolkit support so it cannot leak later
    always_comb begin
        defer_d = defer_q;
        dlen_d  = dlen_q;
        if (take && !err_hit) begin
            if (lnk.cmd.cmd == cswg_pkg::CSWG_CMD_SEEK2 && lnk.cmd.proact && tk_ok) begin
                defer_d = 1'b1;
                dlen_d  = lnk.cmd.proact_len;
            end else if (lnk.cmd.cmd == cswg_pkg::CSWG_CMD_GET_RSP && defer_q && tk_ok) begin
                defer_d = 1'b0;
            end
        end
        if (!tk_ok) begin
            defer_d = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            defer_q <= 1'b0;
            dlen_q  <= 8'h00;
        end else begin
            defer_q <= defer_d;
            dlen_q  <= dlen_d;
        end
    end

    // full buffer holds off cmd_ready, pushing back on the terminal
    cswg_fifo #(.WIDTH(16), .DEPTH(`CSWG_FIFO_DEPTH)) u_fifo (
        .mclk_i      (mclk_i),
        .rst_i       (rst_i),
        .in_valid_i  (lnk.cmd_valid),
        .in_ready_o  (fifo_rdy),
        .in_data_i   (sw),
        .out_valid_o (lnk.sw_valid),
        .out_ready_i (lnk.sw_ready),
        .out_data_o  (lnk.sw)
    );

    // one flop per file byte with its own next-value logic; every byte starts
    // unassigned, so optional items read as F fill until they are written
    for (genvar g = 0; g < FILE_BYTES; g++) begin : g_byte
        logic [7:0] byte_d;

        // clear beats deletion beats alphabet coding beats a plain write
        always_comb begin
            byte_d = file_q[g];
            if (wr_en_i && wr_addr_i == 6'(g)) begin
                if (wr_clear_i) begin
                    byte_d = `CSWG_FILL_BYTE;
                end else if (wr_area_del_i) begin
                    byte_d = `CSWG_AREA_DEL_BYTE;
                end else if (wr_alpha_i) begin
                    byte_d = {1'b0, wr_data_i[`CSWG_ALPHA_MSB-1:0]};
                end else begin
                    byte_d = wr_data_i;
                end
            end
        end

        always_ff @(posedge mclk_i or posedge rst_i) begin
            if (rst_i) begin
                file_q[g] <= `CSWG_FILL_BYTE;
            end else begin
                file_q[g] <= byte_d;
            end
        end
    end

    // read port: one cycle of latency, so a write shows on the read a cycle later
    assign rd_data_d = file_q[rd_addr_i];

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_o <= `CSWG_FILL_BYTE;
        end else begin
            rd_data_o <= rd_data_d;
        end
    end
endmodule : cswg_card

// *** rtl/cswg_consts.svh ***
// Purpose: constants for the card status word generator and its terminal end
// Assumes: one 200 MHz clock, status bytes and file bytes are 8 bits wide
// Notes:   status codes, fill values and field positions live here as macros
`ifndef CSWG_CONSTS_SVH
`define CSWG_CONSTS_SVH

`define CSWG_SW1_OK        8'h90
`define CSWG_SW1_PROACT    8'h91
`define CSWG_SW1_MEM       8'h92
`define CSWG_SW1_BUSY      8'h93
`define CSWG_SW1_REF       8'h94
`define CSWG_SW1_DLERR     8'h9E
`define CSWG_SW1_RSPLEN    8'h9F
`define CSWG_SW1_LEN       8'h67
`define CSWG_SW1_P1P2      8'h6B
`define CSWG_SW1_CLASS     8'h6E
`define CSWG_SW1_TECH      8'h6F
`define CSWG_SW2_NONE      8'h00
`define CSWG_SW2_RANGE     8'h02
`define CSWG_FILL_BYTE     8'hFF
`define CSWG_AREA_DEL_BYTE 8'hFE
`define CSWG_ALPHA_MSB     7
`define CSWG_CLASS_OK      8'hA0
`define CSWG_FIFO_DEPTH    16

`endif

// *** rtl/cswg_pkg.sv ***
// Purpose: shared types for the card status word generator
// Assumes: included constants header is compiled alongside
// Notes:   command kinds and the status reply record
package cswg_pkg;
    typedef enum logic [4:0] {
        CSWG_CMD_SELECT, CSWG_CMD_STATUS, CSWG_CMD_UPD_BIN, CSWG_CMD_UPD_REC,
        CSWG_CMD_RD_BIN, CSWG_CMD_RD_REC, CSWG_CMD_SEEK1, CSWG_CMD_SEEK2,
        CSWG_CMD_INCREASE, CSWG_CMD_CHV, CSWG_CMD_INVAL, CSWG_CMD_RUN_ALG,
        CSWG_CMD_SLEEP, CSWG_CMD_GET_RSP, CSWG_CMD_TERM_PROF, CSWG_CMD_ENVELOPE,
        CSWG_CMD_FETCH, CSWG_CMD_TERM_RSP
    } cswg_cmd_t;

    typedef struct packed {
        cswg_cmd_t   cmd;
        logic [7:0]  cla;
        logic        p12_bad;
        logic        rec_range;
        logic        len_bad;
        logic [7:0]  exp_len;
        logic        fault;
        logic [7:0]  rsp_len;
        logic        proact;
        logic [7:0]  proact_len;
    } cswg_req_t;

    typedef struct packed {
        logic [7:0] sw1;
        logic [7:0] sw2;
    } cswg_sw_t;
endpackage : cswg_pkg

// *** rtl/cswg_if.sv ***
// Purpose: link between terminal end and card end
// Assumes: one clock, valid/ready on the command and status channels
// Notes:   card reads file bytes through a simple read port as well
`timescale 1ns/10ps
interface cswg_if (
    input wire logic mclk_i,
    input wire logic rst_i
);
    logic                 cmd_valid;
    logic                 cmd_ready;
    cswg_pkg::cswg_req_t  cmd;
    logic                 term_tk;
    logic                 sw_valid;
    logic                 sw_ready;
    cswg_pkg::cswg_sw_t   sw;

    modport card (input cmd_valid, cmd, term_tk, sw_ready,
                  output cmd_ready, sw_valid, sw);
    modport term (output cmd_valid, cmd, term_tk, sw_ready,
                  input cmd_ready, sw_valid, sw);
endinterface : cswg_if

// *** rtl/cswg_fifo.sv ***
// Purpose: status word buffer between the decision logic and the link
// Assumes: single clock, first-word-fall-through output
// Notes:   full drops in_ready so the card stops taking commands
`timescale 1ns/10ps
`include "cswg_consts.svh"
module cswg_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = `CSWG_FIFO_DEPTH
) (
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // pointer and occupancy next state
    always_comb begin
        push = in_valid_i && in_ready_o;
        pop  = out_valid_o && out_ready_i;
        wr_d = push ? AW'(wr_q + 1'b1) : wr_q;
        rd_d = pop ? AW'(rd_q + 1'b1) : rd_q;
        cnt_d = (AW+1)'(cnt_q + push - pop);
    end

    assign in_ready_o  = cnt_q != (AW+1)'(DEPTH);
    assign out_valid_o = cnt_q != '0;
    assign out_data_o  = mem_q[rd_q];

    // storage has no reset; only pointers and the count need a defined value
    always_ff @(posedge mclk_i) begin
        if (push) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
    end
endmodule : cswg_fifo

// *** rtl/cswg_term.sv ***
// Purpose: terminal end, issues one command and collects its status
// Assumes: user side supplies a decoded command with a strobe
// Notes:   toolkit support is a static input level
`timescale 1ns/10ps
module cswg_term (
    input  wire logic                mclk_i,
    input  wire logic                rst_i,
    cswg_if.term                     lnk,
    input  wire logic                term_tk_i,
    input  wire logic                req_valid_i,
    output logic                     req_ready_o,
    input  wire cswg_pkg::cswg_req_t req_i,
    output logic                     sw_valid_o,
    output cswg_pkg::cswg_sw_t       sw_o,
    output logic                     proact_seen_o
);
    cswg_pkg::cswg_sw_t sw_q, sw_d;
    logic               vld_q, vld_d, pro_q, pro_d;

    assign lnk.cmd_valid = req_valid_i;
    assign lnk.cmd       = req_i;
    assign lnk.term_tk   = term_tk_i;
    assign lnk.sw_ready  = 1'b1;
    assign req_ready_o   = lnk.cmd_ready;
    assign sw_valid_o    = vld_q;
    assign sw_o          = sw_q;
    assign proact_seen_o = pro_q;

    // capture each status; any toolkit status (91) is flagged, supported or not
    always_comb begin
        vld_d = lnk.sw_valid;
        sw_d  = lnk.sw_valid ? lnk.sw : sw_q;
        pro_d = pro_q;
        if (lnk.sw_valid && lnk.sw.sw1 == 8'h91) begin
            pro_d = 1'b1;
        end
    end

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            sw_q  <= '0;
            vld_q <= 1'b0;
            pro_q <= 1'b0;
        end else begin
            sw_q  <= sw_d;
            vld_q <= vld_d;
            pro_q <= pro_d;
        end
    end
endmodule : cswg_term

// *** tb/cswg_checker.sv ***
// Purpose: watches the card link and ties each status word to its command
// Assumes: terminal end holds sw_ready high, so a status shows one cycle later
// Notes:   toolkit check looks only at the terminal's support level
`timescale 1ns/10ps
module cswg_checker (
    input wire logic                mclk_i,
    input wire logic                rst_i,
    input wire logic                cmd_valid,
    input wire logic                cmd_ready,
    input wire cswg_pkg::cswg_req_t cmd,
    input wire logic                term_tk,
    input wire logic                sw_valid,
    input wire logic                sw_ready,
    input wire cswg_pkg::cswg_sw_t  sw
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    logic tk, pre, ok;
    // taken command, then class and parameters clean, then no fault either
    assign tk  = cmd_valid && cmd_ready && sw_ready;
    assign pre = cmd.cla == 8'hA0 && !cmd.len_bad && !cmd.rec_range && !cmd.p12_bad;
    assign ok  = pre && !cmd.fault;

    class_err_a: assert property (tk && cmd.cla != 8'hA0 |=> sw_valid && sw == 16'h6E00)
        else $error("class error status wrong");
    len_err_a: assert property (tk && cmd.cla == 8'hA0 && cmd.len_bad
        |=> sw_valid && sw == {8'h67, $past(cmd.exp_len)}) else $error("length status wrong");
    rec_range_a: assert property (tk && cmd.cla == 8'hA0 && !cmd.len_bad && cmd.rec_range
        |=> sw == 16'h9402) else $error("record range status wrong");
    param_err_a: assert property (tk && cmd.cla == 8'hA0 && !cmd.len_bad && !cmd.rec_range
        && cmd.p12_bad |=> sw == 16'h6B00) else $error("parameter status wrong");
    fault_err_a: assert property (tk && pre && cmd.fault |=> sw == 16'h6F00)
        else $error("fault status wrong");
    toolkit_gate_a: assert property (sw_valid && !term_tk && !$past(term_tk)
        |-> !(sw.sw1 inside {8'h91, 8'h93, 8'h9E})) else $error("toolkit status leaked");
    sleep_ok_a: assert property (tk && ok && cmd.cmd == cswg_pkg::CSWG_CMD_SLEEP
        |=> sw == 16'h9000) else $error("sleep status wrong");
    seek2_defer_a: assert property (tk && ok && cmd.cmd == cswg_pkg::CSWG_CMD_SEEK2
        |=> sw.sw1 != 8'h91) else $error("seek status not deferred");
    rsp_len_a: assert property (tk && ok && !cmd.proact && cmd.rsp_len != 8'h00
        && cmd.cmd == cswg_pkg::CSWG_CMD_SELECT |=> sw == {8'h9F, $past(cmd.rsp_len)})
        else $error("response length status wrong");

    cover property (tk && cmd.cla != 8'hA0);
    cover property (sw_valid && sw.sw1 == 8'h91);
    cover property (tk && ok && cmd.cmd == cswg_pkg::CSWG_CMD_SEEK2 && cmd.proact);
    cover property (tk && $past(tk));
endmodule : cswg_checker

// *** tb/testbench.sv ***
// Purpose: self-checking bench for the card and terminal ends
// Assumes: one status per command, file reads take one cycle
// Notes:   a burst of back-to-back commands runs through the card's status buffer
`timescale 1ns/10ps
module testbench;
    logic        mclk_i = 1'b0, rst_i = 1'b1, c_tk = 1'b0, t_tk = 1'b0;
    logic        wr_en = 1'b0, wr_clr = 1'b0, wr_alp = 1'b0, wr_del = 1'b0;
    logic [5:0]  wr_a = 6'h00, rd_a = 6'h00;
    logic [7:0]  wr_d = 8'h00, rd_d;
    logic        rq_v = 1'b0, rq_r, sw_v, seen, pend;
    logic [15:0] bx [16];
    cswg_pkg::cswg_req_t rq = '0;
    cswg_pkg::cswg_sw_t  sw;
    int          error_cnt = 0, tests_run = 0, cyc = 0, n, m;

    always #2.5 mclk_i = ~mclk_i;

    cswg_if lnk (.mclk_i(mclk_i), .rst_i(rst_i));
    cswg_card i_cswg_card (.mclk_i(mclk_i), .rst_i(rst_i), .lnk(lnk), .card_tk_i(c_tk),
        .wr_en_i(wr_en), .wr_clear_i(wr_clr), .wr_alpha_i(wr_alp), .wr_area_del_i(wr_del),
        .wr_addr_i(wr_a), .wr_data_i(wr_d), .rd_addr_i(rd_a), .rd_data_o(rd_d),
        .pend_proact_o(pend));
    cswg_term i_cswg_term (.mclk_i(mclk_i), .rst_i(rst_i), .lnk(lnk), .term_tk_i(t_tk),
        .req_valid_i(rq_v), .req_ready_o(rq_r), .req_i(rq), .sw_valid_o(sw_v), .sw_o(sw),
        .proact_seen_o(seen));
    cswg_checker i_cswg_checker (.mclk_i(mclk_i), .rst_i(rst_i), .cmd_valid(lnk.cmd_valid),
        .cmd_ready(lnk.cmd_ready), .cmd(lnk.cmd), .term_tk(lnk.term_tk),
        .sw_valid(lnk.sw_valid), .sw_ready(lnk.sw_ready), .sw(lnk.sw));

    task automatic give_verdict;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // expected status: errors in fixed priority, then toolkit, length, plain end
    function automatic logic [15:0] exp_sw(input cswg_pkg::cswg_req_t r, input logic tk);
        if (r.cla != 8'hA0) return 16'h6E00;
        if (r.len_bad) return {8'h67, r.exp_len};
        if (r.rec_range) return 16'h9402;
        if (r.p12_bad) return 16'h6B00;
        if (r.fault) return 16'h6F00;
        if (r.proact && tk && r.cmd != cswg_pkg::CSWG_CMD_SLEEP) return {8'h91, r.proact_len};
        if (r.rsp_len != 8'h00 && r.cmd inside {cswg_pkg::CSWG_CMD_SELECT,
            cswg_pkg::CSWG_CMD_STATUS, cswg_pkg::CSWG_CMD_SEEK1, cswg_pkg::CSWG_CMD_INCREASE,
            cswg_pkg::CSWG_CMD_RUN_ALG, cswg_pkg::CSWG_CMD_ENVELOPE}) return {8'h9F, r.rsp_len};
        return 16'h9000;
    endfunction : exp_sw

    // request held until the terminal takes it, then wait for the status pulse
    task automatic send(input cswg_pkg::cswg_req_t r, input logic [15:0] exp);
        int k;
        k = 0;
        rq <= r;
        rq_v <= 1'b1;
        do @(posedge mclk_i); while (rq_r !== 1'b1 && ++k < 50);
        rq_v <= 1'b0;
        do @(posedge mclk_i); while (sw_v !== 1'b1 && ++k < 100);
        chk(sw, exp);
    endtask : send

    task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic [2:0] f);
        wr_en <= 1'b1;
        wr_a <= a;
        wr_d <= d;
        {wr_clr, wr_alp, wr_del} <= f;
        @(posedge mclk_i);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [5:0] a, input logic [7:0] e);
        rd_a <= a;
        repeat (2) @(posedge mclk_i);
        chk({8'h00, rd_d}, {8'h00, e});
    endtask : rd

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    initial begin
        logic [5:0] a;
        logic [7:0] d;
        logic [2:0] f;
        cswg_pkg::cswg_req_t r;
        void'($urandom(32'hB274));
        repeat (20) @(posedge mclk_i);
        rst_i <= 1'b0;
        @(posedge mclk_i);
        rd(6'h3F, 8'hFF);
        // plain, seven-bit, cleared and deleted writes on random bytes
        for (int i = 0; i < 8; i++) begin
            a = 6'($urandom);
            d = 8'($urandom) | 8'h80;
            f = (i % 4 == 3) ? 3'h0 : 3'(1 << (i % 4));
            wr(a, d, f);
            rd(a, f[2] ? 8'hFF : f[0] ? 8'hFE : f[1] ? {1'b0, d[6:0]} : d);
        end
        // random commands under each pairing of toolkit support
        for (int i = 0; i < 100; i++) begin
            {t_tk, c_tk} <= 2'(i / 25);
            r = 42'({$urandom, $urandom});
            r.cmd = cswg_pkg::cswg_cmd_t'(5'($urandom_range(17, 0)));
            if (r.cmd == cswg_pkg::CSWG_CMD_SEEK2) r.cmd = cswg_pkg::CSWG_CMD_SEEK1;
            if (r.cmd == cswg_pkg::CSWG_CMD_GET_RSP) r.proact = 1'b0;
            if ($urandom_range(3, 0) != 0) r.cla = 8'hA0;
            if ($urandom_range(1, 0)) {r.len_bad, r.rec_range, r.p12_bad, r.fault} = 4'h0;
            if ($urandom_range(1, 0)) r.rsp_len = 8'h00;
            send(r, exp_sw(r, i >= 75));
        end
        // corners: longest length, empty expected length, deferred toolkit status
        r = '0;
        r.cla = 8'hA0;
        r.rsp_len = 8'hFF;
        send(r, 16'h9FFF);
        r.len_bad = 1'b1;
        send(r, 16'h6700);
        r = '0;
        r.cla = 8'hA0;
        r.cmd = cswg_pkg::CSWG_CMD_SEEK2;
        r.proact = 1'b1;
        r.proact_len = 8'h2C;
        send(r, 16'h9000);
        chk(16'(pend), 16'h0001);
        r.cmd = cswg_pkg::CSWG_CMD_GET_RSP;
        r.proact = 1'b0;
        send(r, 16'h912C);
        chk(16'({pend, seen}), 16'h0001);
        // sixteen commands on consecutive edges; statuses must come back in order
        n = 0;
        m = 0;
        for (int i = 0; i < 20; i++) begin
            r = '0;
            r.cla = 8'hA0;
            r.cmd = cswg_pkg::CSWG_CMD_SELECT;
            r.rsp_len = 8'($urandom_range(255, 1));
            if (i < 16) bx[i] = exp_sw(r, 1'b1);
            rq <= r;
            rq_v <= (i < 16);
            @(posedge mclk_i);
            if (rq_v === 1'b1 && rq_r === 1'b1) n++;
            if (sw_v === 1'b1) begin
                chk(sw, bx[m[3:0]]);
                m++;
            end
        end
        chk(16'(n), 16'h0010);
        chk(16'(m), 16'h0010);
        give_verdict();
    end
endmodule : testbench
